// *** gdp_regs.sv ***
// gdp_regs: drain threshold and bridge timing registers of a three-phase gate driver
// assumes a decoded serial register port on the core clock and raw PWM pins
`timescale 1ns/1ps
module gdp_regs #(
    parameter int RETRY_UNIT_CYC = gdp_pkg::GDP_RETRY_UNIT_CYC
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // register port
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [5:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic [7:0]                  reg_rdata,
    // pwm pins and strength codes
    input  wire logic [2:0]             pwm_hi_pin,
    input  wire logic [2:0]             pwm_lo_pin,
    input  wire logic [23:0]            gate_source_strength,
    // settings out
    output gdp_pkg::gdp_trip_set_t      trip_levels,
    output logic [23:0]                 fault_recovery_wait,
    output logic [9:0]                  peak_current_window,
    output logic                        drive_window_limit_en,
    output logic [12:0]                 drive_window_limit_cyc,
    output logic                        regs_locked,
    // gate outputs
    output gdp_pkg::gdp_gate_t          gates
);
    import gdp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] phase_a_drain_threshold;
    logic [7:0] phase_b_drain_threshold;
    logic [7:0] phase_c_drain_threshold;
    logic [7:0] bridge_timing_control;
    logic [2:0] lock_reg;
    logic       locked;
    logic       wr_ok;
    logic       force_limit;
    logic [7:0] timing_next;
    logic [7:0] rd_mux;

    function automatic logic is_weak(input logic [3:0] code);
        return code <= GDP_STRENGTH_FORCE_MAX;
    endfunction

    logic       wr_phase_a;
    logic       wr_phase_b;
    logic       wr_phase_c;
    logic       wr_timing;
    logic       wr_lock;

    assign locked     = (lock_reg == GDP_LOCK_CODE);
    assign wr_ok      = reg_wr && !locked;
    assign wr_phase_a = wr_ok && (reg_addr == GDP_OFS_PHASE_A);
    assign wr_phase_b = wr_ok && (reg_addr == GDP_OFS_PHASE_B);
    assign wr_phase_c = wr_ok && (reg_addr == GDP_OFS_PHASE_C);
    assign wr_timing  = wr_ok && (reg_addr == GDP_OFS_TIMING);
    assign wr_lock    = reg_wr && (reg_addr == GDP_OFS_LOCK);

    always_comb begin
        force_limit = 1'b0;
        for (int i = 0; i < 6; i++) begin
            force_limit = force_limit | is_weak(gate_source_strength[i*4 +: 4]);
        end
    end

    // a forced limit wins over a clearing write
    always_comb begin
        timing_next = bridge_timing_control;
        if (wr_timing) begin
            timing_next = reg_wdata;
        end
        if (force_limit) begin
            timing_next[GDP_BIT_LIMIT_EN] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_a_drain_threshold <= GDP_RST_THRESH;
            phase_b_drain_threshold <= GDP_RST_THRESH;
            phase_c_drain_threshold <= GDP_RST_THRESH;
            bridge_timing_control   <= GDP_RST_TIMING;
        end else begin
            if (wr_phase_a) begin
                phase_a_drain_threshold <= reg_wdata;
            end
            if (wr_phase_b) begin
                phase_b_drain_threshold <= reg_wdata;
            end
            if (wr_phase_c) begin
                phase_c_drain_threshold <= reg_wdata;
            end
            bridge_timing_control <= timing_next;
        end
    end

    // lock field stays writable while locked, but only the unlock code acts
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_reg <= GDP_RST_LOCK;
        end else if (wr_lock) begin
            if (!locked && reg_wdata[GDP_POS_LOCK +: 3] == GDP_LOCK_CODE) begin
                lock_reg <= GDP_LOCK_CODE;
            end else if (locked && reg_wdata[GDP_POS_LOCK +: 3] == GDP_UNLOCK_CODE) begin
                lock_reg <= GDP_UNLOCK_CODE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read back
    always_comb begin
        case (reg_addr)
            GDP_OFS_PHASE_A: rd_mux = phase_a_drain_threshold;
            GDP_OFS_PHASE_B: rd_mux = phase_b_drain_threshold;
            GDP_OFS_PHASE_C: rd_mux = phase_c_drain_threshold;
            GDP_OFS_TIMING:  rd_mux = bridge_timing_control;
            GDP_OFS_LOCK:    rd_mux = {lock_reg, 5'h00};
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decoded settings
    logic [1:0]  retry_code;
    logic [1:0]  dead_code;
    logic [1:0]  peak_code;
    logic [9:0]  dead_cyc;
    logic [9:0]  peak_cyc;
    logic [23:0] retry_cyc;

    assign retry_code = bridge_timing_control[GDP_POS_RETRY +: 2];
    assign dead_code  = bridge_timing_control[GDP_POS_DEAD +: 2];
    assign peak_code  = bridge_timing_control[GDP_POS_PEAK +: 2];
    assign retry_cyc  = 24'(RETRY_UNIT_CYC) * 24'({22'h0, retry_code} + 24'h1);
    assign dead_cyc   = GDP_DEAD_BASE_CYC << dead_code;
    assign peak_cyc   = (peak_code == 2'h0) ? GDP_PEAK_1_CYC :
                        (peak_code == 2'h1) ? GDP_PEAK_2_CYC :
                        (peak_code == 2'h2) ? GDP_PEAK_3_CYC : GDP_PEAK_4_CYC;

    always_ff @(posedge clk) begin
        if (rst) begin
            trip_levels            <= {3{GDP_RST_THRESH}};
            fault_recovery_wait    <= 24'h000000;
            peak_current_window    <= 10'h000;
            drive_window_limit_en  <= 1'b1;
            drive_window_limit_cyc <= GDP_DRIVE_LIMIT_CYC;
            regs_locked            <= 1'b0;
        end else begin
            trip_levels.phase_a    <= phase_a_drain_threshold;
            trip_levels.phase_b    <= phase_b_drain_threshold;
            trip_levels.phase_c    <= phase_c_drain_threshold;
            fault_recovery_wait    <= retry_cyc;
            peak_current_window    <= peak_cyc;
            drive_window_limit_en  <= bridge_timing_control[GDP_BIT_LIMIT_EN];
            drive_window_limit_cyc <= GDP_DRIVE_LIMIT_CYC;
            regs_locked            <= locked;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pwm pin synchronisers: a change counts when stages two and three agree
    logic [5:0] sync1_reg, sync2_reg, sync3_reg, pwm_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
            sync3_reg <= 6'h00;
            pwm_reg   <= 6'h00;
        end else begin
            sync1_reg <= {pwm_hi_pin, pwm_lo_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pwm_reg   <= (pwm_reg & ~(sync2_reg ^ sync3_reg)) == pwm_reg &&
                         sync2_reg == sync3_reg ? sync3_reg :
                         ((sync2_reg ~^ sync3_reg) & sync3_reg) |
                         ((sync2_reg ^ sync3_reg) & pwm_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output stages
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            gdp_half_bridge u_hb (
                .clk         (clk),
                .rst         (rst),
                .hi_cmd      (pwm_reg[3 + g]),
                .lo_cmd      (pwm_reg[g]),
                .all_float   (bridge_timing_control[GDP_BIT_FLOAT]),
                .dead_cycles (dead_cyc),
                .hi_on       (gates.hi_on[g]),
                .lo_on       (gates.lo_on[g]),
                .outs_oe     (gates.hi_oe[g])
            );
            assign gates.lo_oe[g] = gates.hi_oe[g];
        end
    endgenerate

endmodule

// *** gdp_pkg.sv ***
// gdp_pkg: offsets, reset values, field layout and timing constants
// assumes a 200 MHz core clock; shared by the register bank and the half-bridge stage
package gdp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets and reset values
    localparam logic [5:0] GDP_OFS_PHASE_A = 6'h09;
    localparam logic [5:0] GDP_OFS_PHASE_B = 6'h0A;
    localparam logic [5:0] GDP_OFS_PHASE_C = 6'h0B;
    localparam logic [5:0] GDP_OFS_TIMING  = 6'h0C;
    localparam logic [5:0] GDP_OFS_LOCK    = 6'h0D;
    localparam logic [7:0] GDP_RST_THRESH  = 8'h99;
    localparam logic [7:0] GDP_RST_TIMING  = 8'h2F;
    localparam logic [2:0] GDP_RST_LOCK    = 3'h3;
    localparam logic [2:0] GDP_LOCK_CODE   = 3'h6;
    localparam logic [2:0] GDP_UNLOCK_CODE = 3'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int GDP_BIT_FLOAT    = 7;
    localparam int GDP_POS_RETRY    = 5;
    localparam int GDP_POS_DEAD     = 3;
    localparam int GDP_BIT_LIMIT_EN = 2;
    localparam int GDP_POS_PEAK     = 0;
    localparam int GDP_POS_LOCK     = 5;
    localparam int GDP_LOW_LVL_POS  = 4;
    localparam logic [3:0] GDP_STRENGTH_FORCE_MAX = 4'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int GDP_CLK_PERIOD_NS   = 5;
    localparam int GDP_DEAD_BASE_NS    = 500;
    localparam int GDP_PEAK_1_NS       = 500;
    localparam int GDP_PEAK_2_NS       = 1000;
    localparam int GDP_PEAK_3_NS       = 2000;
    localparam int GDP_PEAK_4_NS       = 3000;
    localparam int GDP_DRIVE_LIMIT_US  = 20;
    localparam int GDP_RETRY_BASE_MS   = 2;
    localparam int GDP_RETRY_UNIT_CYC  = GDP_RETRY_BASE_MS * 1000000 / GDP_CLK_PERIOD_NS;

    // least time, rounded up to whole cycles, never below one
    function automatic int gdp_ns_to_cyc(input int ns);
        int c;
        c = (ns + GDP_CLK_PERIOD_NS - 1) / GDP_CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [9:0]  GDP_DEAD_BASE_CYC   = 10'(gdp_ns_to_cyc(GDP_DEAD_BASE_NS));
    localparam logic [9:0]  GDP_PEAK_1_CYC      = 10'(gdp_ns_to_cyc(GDP_PEAK_1_NS));
    localparam logic [9:0]  GDP_PEAK_2_CYC      = 10'(gdp_ns_to_cyc(GDP_PEAK_2_NS));
    localparam logic [9:0]  GDP_PEAK_3_CYC      = 10'(gdp_ns_to_cyc(GDP_PEAK_3_NS));
    localparam logic [9:0]  GDP_PEAK_4_CYC      = 10'(gdp_ns_to_cyc(GDP_PEAK_4_NS));
    localparam logic [12:0] GDP_DRIVE_LIMIT_CYC = 13'(gdp_ns_to_cyc(GDP_DRIVE_LIMIT_US * 1000));

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [3:0] low;
        logic [3:0] high;
    } gdp_trip_t;

    typedef struct packed {
        gdp_trip_t phase_c;
        gdp_trip_t phase_b;
        gdp_trip_t phase_a;
    } gdp_trip_set_t;

    typedef struct packed {
        logic [2:0] hi_on;
        logic [2:0] lo_on;
        logic [2:0] hi_oe;
        logic [2:0] lo_oe;
    } gdp_gate_t;

    typedef enum logic [2:0] {
        GDP_HB_OFF = 3'b001,
        GDP_HB_HI  = 3'b010,
        GDP_HB_LO  = 3'b100
    } gdp_hb_state_t;

endpackage

// *** gdp_half_bridge.sv ***
// gdp_half_bridge: one half-bridge output stage with dead-time insertion
// assumes synchronised commands on the same clock
`timescale 1ns/1ps
module gdp_half_bridge (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // commands and settings
    input  wire logic       hi_cmd,
    input  wire logic       lo_cmd,
    input  wire logic       all_float,
    input  wire logic [9:0] dead_cycles,
    // gate outputs
    output logic            hi_on,
    output logic            lo_on,
    output logic            outs_oe
);
    import gdp_pkg::*;

    gdp_hb_state_t state_reg, state_next;
    logic [9:0]    dead_reg, dead_next;
    gdp_hb_state_t want;

    assign want = (hi_cmd && !lo_cmd) ? GDP_HB_HI :
                  (lo_cmd && !hi_cmd) ? GDP_HB_LO : GDP_HB_OFF;

    ////////////////////////////////////////////////////////////////////////////////
    // both switches off, then wait out the dead time
    always_comb begin
        state_next = state_reg;
        dead_next  = (dead_reg != 10'h000) ? dead_reg - 10'h001 : dead_reg;
        case (state_reg)
            GDP_HB_OFF: begin
                if (want != GDP_HB_OFF && dead_reg == 10'h000) begin
                    state_next = want;
                end
            end
            GDP_HB_HI, GDP_HB_LO: begin
                if (want != state_reg || all_float) begin
                    state_next = GDP_HB_OFF;
                    dead_next  = dead_cycles;
                end
            end
            default: begin
                state_next = GDP_HB_OFF;
            end
        endcase
        if (all_float && state_reg == GDP_HB_OFF) begin
            state_next = GDP_HB_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= GDP_HB_OFF;
            dead_reg  <= 10'h000;
            hi_on     <= 1'b0;
            lo_on     <= 1'b0;
            outs_oe   <= 1'b1;
        end else begin
            state_reg <= state_next;
            dead_reg  <= dead_next;
            hi_on     <= (state_next == GDP_HB_HI);
            lo_on     <= (state_next == GDP_HB_LO);
            outs_oe   <= !all_float;
        end
    end

endmodule

// *** gdp_host_model.sv ***
// gdp_host_model: host side of the register port and the pwm pins
// assumes one-cycle strobes sampled on clk, read data valid after the read edge
`timescale 1ns/1ps
module gdp_host_model (
    // clock
    input  wire logic       clk,
    // register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [5:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // pwm pins
    output logic [2:0]      pwm_hi_pin,
    output logic [2:0]      pwm_lo_pin
);
    import gdp_pkg::*;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        pwm_hi_pin = 3'h0;
        pwm_lo_pin = 3'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // released data shows the inverse of the last value
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic unlock();
        wr(GDP_OFS_LOCK, {GDP_UNLOCK_CODE, 5'h00});
    endtask
    task automatic set_pwm(input logic [2:0] h, input logic [2:0] l);
        @(posedge clk);
        #1;
        pwm_hi_pin = h;
        pwm_lo_pin = l;
    endtask
endmodule

// *** gdp_regs_checker.sv ***
// gdp_regs_checker: port-level assertions for the register bank
// assumes binding onto gdp_regs, one clock, rst synchronous
`timescale 1ns/1ps
module gdp_regs_checker #(
    parameter int RETRY_UNIT_CYC = 40
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // register port
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [5:0]             reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic [7:0]             reg_rdata,
    // pins and strength
    input wire logic [2:0]             pwm_hi_pin,
    input wire logic [2:0]             pwm_lo_pin,
    input wire logic [23:0]            gate_source_strength,
    // settings and gates
    input wire gdp_pkg::gdp_trip_set_t trip_levels,
    input wire logic [23:0]            fault_recovery_wait,
    input wire logic [9:0]             peak_current_window,
    input wire logic                   drive_window_limit_en,
    input wire logic [12:0]            drive_window_limit_cyc,
    input wire logic                   regs_locked,
    input wire gdp_pkg::gdp_gate_t     gates
);
    import gdp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [9:0] off_cnt_reg;
    logic       wr_ok;
    logic       low_code;
    assign wr_ok = reg_wr && !regs_locked;
    assign low_code = (gate_source_strength[3:0] <= 4'h3) || (gate_source_strength[7:4] <= 4'h3)
        || (gate_source_strength[11:8] <= 4'h3) || (gate_source_strength[15:12] <= 4'h3)
        || (gate_source_strength[19:16] <= 4'h3) || (gate_source_strength[23:20] <= 4'h3);
    // cycles phase A has had both switches off
    always_ff @(posedge clk) begin
        if (rst)
            off_cnt_reg <= 10'h3FF;
        else if (gates.hi_on[0] || gates.lo_on[0])
            off_cnt_reg <= 10'h000;
        else if (off_cnt_reg != 10'h3FF)
            off_cnt_reg <= off_cnt_reg + 10'h001;
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_trip_a;
        wr_ok && reg_addr == 6'h09 |-> ##2 trip_levels.phase_a == $past(reg_wdata, 2);
    endproperty
    a_trip_a: assert property (p_trip_a) else $error("phase a trip copy wrong");
    property p_trip_b;
        wr_ok && reg_addr == 6'h0A |-> ##2 trip_levels.phase_b == $past(reg_wdata, 2);
    endproperty
    a_trip_b: assert property (p_trip_b) else $error("phase b trip copy wrong");
    property p_trip_c;
        wr_ok && reg_addr == 6'h0B |-> ##2 trip_levels.phase_c == $past(reg_wdata, 2);
    endproperty
    a_trip_c: assert property (p_trip_c) else $error("phase c trip copy wrong");
    property p_float;
        wr_ok && reg_addr == 6'h0C && reg_wdata[7] |-> ##2 {gates.hi_oe, gates.lo_oe} == 6'h00;
    endproperty
    a_float: assert property (p_float) else $error("outputs not floated");
    property p_retry;
        wr_ok && reg_addr == 6'h0C |->
            ##2 fault_recovery_wait == 24'(RETRY_UNIT_CYC * ($past(reg_wdata[6:5], 2) + 1));
    endproperty
    a_retry: assert property (p_retry) else $error("retry wait wrong");
    property p_peak;
        wr_ok && reg_addr == 6'h0C && reg_wdata[1:0] == 2'h0 |-> ##2 peak_current_window == 10'h064;
    endproperty
    a_peak: assert property (p_peak) else $error("peak window wrong");
    property p_limit;
        low_code |-> ##[1:3] drive_window_limit_en;
    endproperty
    a_limit: assert property (p_limit) else $error("limit not forced");
    property p_lock;
        regs_locked && reg_wr && reg_addr == 6'h09 |-> ##2 $stable(trip_levels.phase_a);
    endproperty
    a_lock: assert property (p_lock) else $error("locked write took effect");
    property p_dead;
        $rose(gates.lo_on[0]) |-> off_cnt_reg >= 10'h064 && !gates.hi_on[0];
    endproperty
    a_dead: assert property (p_dead) else $error("dead time too short");
    property p_dead_hi;
        $rose(gates.hi_on[0]) |-> off_cnt_reg >= 10'h064 && !gates.lo_on[0];
    endproperty
    a_dead_hi: assert property (p_dead_hi) else $error("hi dead time too short");
endmodule
bind gdp_regs gdp_regs_checker #(.RETRY_UNIT_CYC(RETRY_UNIT_CYC)) gdp_regs_checker_inst (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pwm_hi_pin(pwm_hi_pin),
    .pwm_lo_pin(pwm_lo_pin), .gate_source_strength(gate_source_strength),
    .trip_levels(trip_levels), .fault_recovery_wait(fault_recovery_wait),
    .peak_current_window(peak_current_window), .drive_window_limit_en(drive_window_limit_en),
    .drive_window_limit_cyc(drive_window_limit_cyc), .regs_locked(regs_locked), .gates(gates));

// *** gate_drive_protection_timing_regs_tb.sv ***
// gate_drive_protection_timing_regs_tb: self-checking bench for gdp_regs
// assumes gdp_host_model as the register and pwm driver, 200 MHz clock
`timescale 1ns/1ps
module gate_drive_protection_timing_regs_tb;
    import gdp_pkg::*;
    localparam int UNIT = 40;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic [2:0] pwm_hi, pwm_lo;
    logic [23:0] strength = 24'hFFFFFF;
    logic [23:0] retry;
    gdp_trip_set_t trip;
    logic [9:0] peak;
    logic limit_en, locked;
    logic [12:0] limit_cyc;
    gdp_gate_t gates;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    gdp_host_model gdp_host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pwm_hi_pin(pwm_hi), .pwm_lo_pin(pwm_lo));
    gdp_regs #(.RETRY_UNIT_CYC(UNIT)) gdp_regs_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pwm_hi_pin(pwm_hi), .pwm_lo_pin(pwm_lo), .gate_source_strength(strength),
        .trip_levels(trip), .fault_recovery_wait(retry), .peak_current_window(peak),
        .drive_window_limit_en(limit_en), .drive_window_limit_cyc(limit_cyc),
        .regs_locked(locked), .gates(gates));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            $display("MISMATCH %0t timeout", $time);
            give_verdict();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        gdp_host_model_inst.rd(a, rv);
        chk(rv, exp, "readback");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // waits for phase A high (sel 0) or low (sel 1) gate to reach v
    task automatic wait_gate(input int sel, input logic v, output int n);
        n = 0;
        while ((sel ? gates.lo_on[0] : gates.hi_on[0]) !== v && n < 2000) begin
            cyc(1);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk(6'h09, 8'h99);
        rchk(6'h0A, 8'h99);
        rchk(6'h0B, 8'h99);
        rchk(6'h0C, 8'h2F);
        rchk(6'h3F, 8'h00);
        chk(limit_cyc, 13'hFA0, "limit window");
        $display("test reset done");
    endtask
    task automatic t_fields();
        gdp_host_model_inst.wr(6'h09, 8'h0F);
        gdp_host_model_inst.wr(6'h0A, 8'hF0);
        gdp_host_model_inst.wr(6'h0B, 8'h5A);
        cyc(2);
        chk(trip, 24'h5AF00F, "trip fields");
        rchk(6'h0B, 8'h5A);
        $display("test fields done");
    endtask
    task automatic t_timing();
        logic [9:0] tbl [4] = '{10'h064, 10'h0C8, 10'h190, 10'h258};
        for (int c = 0; c < 4; c++) begin
            gdp_host_model_inst.wr(6'h0C, {1'b0, 2'(c), 2'(c), 1'b1, 2'(c)});
            cyc(2);
            chk(retry, 24'(UNIT * (c + 1)), "retry wait");
            chk(peak, tbl[c], "peak window");
        end
        $display("test timing done");
    endtask
    task automatic t_dead();
        int n;
        for (int d = 0; d < 4; d++) begin
            gdp_host_model_inst.wr(6'h0C, {3'h1, 2'(d), 3'h7});
            gdp_host_model_inst.set_pwm(3'h1, 3'h0);
            wait_gate(0, 1'b1, n);
            gdp_host_model_inst.set_pwm(3'h0, 3'h1);
            wait_gate(0, 1'b0, n);
            wait_gate(1, 1'b1, n);
            chk(n >= (100 << d) - 1 && n <= (100 << d) + 2, 1'b1, "dead time");
            gdp_host_model_inst.set_pwm(3'h0, 3'h0);
        end
        $display("test dead done");
    endtask
    task automatic t_limit();
        gdp_host_model_inst.wr(6'h0C, 8'h2B);
        cyc(2);
        chk(limit_en, 1'b0, "limit cleared");
        strength = 24'hFFF3FF;
        cyc(4);
        chk(limit_en, 1'b1, "limit forced");
        rchk(6'h0C, 8'h2F);
        strength = 24'hFFFFFF;
        gdp_host_model_inst.wr(6'h0C, 8'hAF);
        cyc(2);
        chk({gates.hi_oe, gates.lo_oe}, 6'h00, "float");
        gdp_host_model_inst.wr(6'h0C, 8'h2F);
        cyc(2);
        chk({gates.hi_oe, gates.lo_oe}, 6'h3F, "driven");
        $display("test limit done");
    endtask
    task automatic t_lock();
        gdp_host_model_inst.wr(6'h0D, 8'hC0);
        cyc(2);
        chk(locked, 1'b1, "locked");
        gdp_host_model_inst.wr(6'h09, 8'h12);
        gdp_host_model_inst.wr(6'h0D, 8'h00);
        rchk(6'h09, 8'h0F);
        rchk(6'h0D, 8'hC0);
        gdp_host_model_inst.unlock();
        gdp_host_model_inst.wr(6'h09, 8'h12);
        rchk(6'h09, 8'h12);
        $display("test lock done");
    endtask
    task automatic t_phases();
        gdp_host_model_inst.set_pwm(3'h6, 3'h0);
        cyc(6);
        chk({gates.hi_on, gates.lo_on}, 6'h30, "phase b c high on");
        gdp_host_model_inst.set_pwm(3'h6, 3'h2);
        cyc(6);
        chk({gates.hi_on, gates.lo_on}, 6'h20, "both set gives off");
        gdp_host_model_inst.wr(6'h0C, 8'hAF);
        cyc(2);
        chk({gates.hi_on, gates.hi_oe}, 6'h00, "float drops gates");
        gdp_host_model_inst.set_pwm(3'h0, 3'h0);
        gdp_host_model_inst.wr(6'h0C, 8'h2F);
        cyc(2);
        $display("test phases done");
    endtask
    task automatic t_rerun();
        gdp_host_model_inst.wr(6'h0C, 8'h50);
        gdp_host_model_inst.wr(6'h0D, 8'hC0);
        rst = 1'b1;
        cyc(4);
        rst = 1'b0;
        chk(locked, 1'b0, "lock cleared by reset");
        rchk(6'h09, 8'h99);
        rchk(6'h0B, 8'h99);
        rchk(6'h0C, 8'h2F);
        rchk(6'h0D, 8'h60);
        $display("test rerun done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_fields();
        t_timing();
        t_dead();
        t_phases();
        t_limit();
        t_lock();
        t_rerun();
        give_verdict();
    end
endmodule
